// ==== shared/cscp_pkg.sv ====
// Constants, codes and state types of the compass serial command port
package cscp_pkg;

	// Clock rates
	localparam int CLK_HZ   = 250_000_000;
	localparam int CLK_KHZ  = CLK_HZ / 1000;
	localparam int LINK_HZ  = 15_625_000;

	// Serial link times in microseconds
	localparam int CS_LOW_US = 20;
	localparam int SCK_HI_US = 16;
	localparam int SCK_LO_US = 22;
	localparam int GAP_US    = 50;

	// Least times round up to whole clock cycles
	localparam int CS_LOW_CYC = (CS_LOW_US * CLK_KHZ + 999) / 1000;
	localparam int SCK_HI_CYC = (SCK_HI_US * CLK_KHZ + 999) / 1000;
	localparam int SCK_LO_CYC = (SCK_LO_US * CLK_KHZ + 999) / 1000;
	localparam int GAP_CYC    = (GAP_US * CLK_KHZ + 999) / 1000;

	// Character framing and baud rates
	localparam int BAUD_MAX      = 19200;
	localparam int BAUD_MIN      = 2400;
	localparam int UART_BIT_CYC  = CLK_HZ / BAUD_MAX;
	localparam int LINK_BIT_CYC  = LINK_HZ / BAUD_MAX;
	localparam int UART_DATA_BITS = 8;
	localparam logic [3:0] UART_LAST_BIT = 4'h9;
	localparam logic [1:0] BAUD_SEL_19200 = 2'h3;

	// Timer width, covers the slowest bit time
	localparam int TMR_W = 20;

	// Layout of the synchronised pin vector
	localparam int PIN_N       = 5;
	localparam int PIN_SPI     = 4;
	localparam int PIN_BAUD_LO = 2;
	localparam int PIN_CS      = 1;
	localparam int PIN_SDI     = 0;
	localparam logic [PIN_N-1:0] PIN_RST = 5'h0F;

	// Level of the serial clock between transfers
	localparam logic idle_clock_level_setting = 1'b0;

	// Characters
	localparam logic [7:0] CH_S    = 8'h73;
	localparam logic [7:0] CH_E    = 8'h65;
	localparam logic [7:0] CH_UH   = 8'h48;
	localparam logic [7:0] CH_LH   = 8'h68;
	localparam logic [7:0] CH_UM   = 8'h4D;
	localparam logic [7:0] CH_STAR = 8'h2A;
	localparam logic [7:0] CH_CR   = 8'h0D;
	localparam logic [7:0] CH_LF   = 8'h0A;

	// Pending UART command
	localparam logic [1:0] PEND_NONE = 2'h0;
	localparam logic [1:0] PEND_HEAD = 2'h1;
	localparam logic [1:0] PEND_FLD  = 2'h2;

	typedef enum logic [5:0] {
		SP_IDLE = 6'h01,
		SP_ARM  = 6'h02,
		SP_LOW  = 6'h04,
		SP_HIGH = 6'h08,
		SP_GAP  = 6'h10,
		SP_DONE = 6'h20
	} cscp_spi_st_t;

	typedef enum logic [2:0] {
		TX_IDLE  = 3'h1,
		TX_FETCH = 3'h2,
		TX_SEND  = 3'h4
	} cscp_tx_st_t;

endpackage : cscp_pkg

// ==== shared/cscp_rx_if.sv ====
// Received-character carrier from the link domain to the core domain
`timescale 1ns/1ps
interface cscp_rx_if;
	logic       tgl;
	logic [7:0] chr;
	modport link (output tgl, output chr);
	modport core (input tgl, input chr);
endinterface : cscp_rx_if

// ==== rtl/cscp_uart_rx.sv ====
// UART character receiver running on the link clock
`timescale 1ns/1ps
module cscp_uart_rx
	import cscp_pkg::*;
#(
	parameter int unsigned T_BIT = LINK_BIT_CYC
)
(
	input  wire logic       link_clk_i,
	input  wire logic       arst_n_i,
	input  wire logic       rx_i,
	input  wire logic [1:0] baud_sel_i,
	cscp_rx_if.link         bus
);

	logic [2:0]  rx_s1, rx_s2, rx_s3, rx_f;
	logic        busy;
	logic [15:0] cnt;
	logic [3:0]  bitn;
	logic [7:0]  sh;
	logic        tgl;
	logic [7:0]  chr;

	// Divider must fit the 16-bit counter at the slowest rate
	if (T_BIT < 1 || (T_BIT * 8) > 65535)
	begin : g_chk
		$error("cscp_uart_rx: bit time out of range");
	end

	////////////////////////////////////////////////////////////////
	// Three-stage pin sampling, change taken when stages two and three agree
	always_ff @(posedge link_clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			rx_s1 <= 3'h7;
			rx_s2 <= 3'h7;
			rx_s3 <= 3'h7;
			rx_f  <= 3'h7;
		end
		else
		begin
			rx_s1 <= {baud_sel_i, rx_i};
			rx_s2 <= rx_s1;
			rx_s3 <= rx_s2;
			rx_f  <= (rx_s2 & rx_s3) | (rx_f & (rx_s2 | rx_s3));
		end
	end

	wire        rx_line  = rx_f[0];
	wire [15:0] bit_div  = 16'(T_BIT) << (2'h3 - rx_f[2:1]);
	wire        cnt_done = (cnt == 16'h0000);
	wire        start    = !busy && !rx_line;
	wire        stop_ok  = busy && cnt_done && (bitn == UART_LAST_BIT) && rx_line;

	////////////////////////////////////////////////////////////////
	// Start, eight data bits LSB first, stop; bad stop drops the character
	always_ff @(posedge link_clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			busy <= 1'b0;
			cnt  <= 16'h0000;
			bitn <= 4'h0;
			sh   <= 8'h00;
		end
		else if (start)
		begin
			busy <= 1'b1;
			cnt  <= bit_div >> 1;
			bitn <= 4'h0;
		end
		else if (busy && cnt_done)
		begin
			cnt  <= bit_div - 16'h0001;
			bitn <= bitn + 4'h1;
			sh   <= (bitn == 4'h0) ? sh : {rx_line, sh[7:1]};
			busy <= !(((bitn == 4'h0) && rx_line) || (bitn == UART_LAST_BIT));
		end
		else if (busy)
			cnt <= cnt - 16'h0001;
	end

	// Word held stable long after the toggle, so the core reads it settled
	always_ff @(posedge link_clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			tgl <= 1'b0;
			chr <= 8'h00;
		end
		else if (stop_ok)
		begin
			tgl <= ~tgl;
			chr <= sh;
		end
	end

	assign bus.tgl = tgl;
	assign bus.chr = chr;

	////////////////////////////////////////////////////////////////
	property p_stop_drop;
		@(posedge link_clk_i) disable iff (!arst_n_i)
		busy && cnt_done && (bitn == UART_LAST_BIT) && !rx_line |=> $stable(tgl) && !busy;
	endproperty
	a_stop_drop: assert property (p_stop_drop)
		else $error("character with low stop bit was delivered");

endmodule : cscp_uart_rx

// ==== rtl/cscp_top.sv ====
// Compass serial command port: SPI session engine and UART command path
`timescale 1ns/1ps
module cscp_top
	import cscp_pkg::*;
#(
	parameter int unsigned T_CS  = CS_LOW_CYC,
	parameter int unsigned T_LO  = SCK_LO_CYC,
	parameter int unsigned T_GAP = GAP_CYC,
	parameter int unsigned T_BIT = UART_BIT_CYC,
	parameter int unsigned T_HI  = SCK_HI_CYC,
	parameter int unsigned T_RXB = LINK_BIT_CYC
)
(
	input  wire logic        mclk_i,
	input  wire logic        arst_n_i,
	input  wire logic        link_clk_i,
	input  wire logic        spi_mode_i,
	input  wire logic [1:0]  baud_sel_i,
	input  wire logic        cs_n_i,
	input  wire logic        sdi_rx_i,
	input  wire logic [15:0] heading_x10_i,
	input  wire logic        report_tick_i,
	input  wire logic [7:0]  report_char_i,
	output logic             sck_o,
	output logic             sdo_tx_o,
	output logic [5:0]       report_idx_o,
	output logic             heading_mode_o
);

	// Refuse zero timings, and a bit or gap time the timer cannot hold
	if (T_CS < 1 || T_LO < 1 || T_GAP < 1 || T_BIT < 1 || T_HI < 1
		|| (T_BIT * 8) >= (1 << TMR_W) || T_GAP >= (1 << TMR_W))
	begin : g_chk
		$error("cscp_top: timing parameter out of range");
	end

	////////////////////////////////////////////////////////////////
	// Pin sampling
	logic [PIN_N-1:0] pin_s1, pin_s2, pin_s3, pin_f;
	wire  [PIN_N-1:0] pin_raw = {spi_mode_i, baud_sel_i, cs_n_i, sdi_rx_i};

	always_ff @(posedge mclk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			pin_s1 <= PIN_RST;
			pin_s2 <= PIN_RST;
			pin_s3 <= PIN_RST;
			pin_f  <= PIN_RST;
		end
		else
		begin
			pin_s1 <= pin_raw;
			pin_s2 <= pin_s1;
			pin_s3 <= pin_s2;
			pin_f  <= (pin_s2 & pin_s3) | (pin_f & (pin_s2 | pin_s3));
		end
	end

	wire       spi_mode = pin_f[PIN_SPI];
	wire [1:0] baud_f   = pin_f[PIN_BAUD_LO+1:PIN_BAUD_LO];
	wire       cs_act   = spi_mode && !pin_f[PIN_CS];
	wire       sdi_f    = pin_f[PIN_SDI];

	////////////////////////////////////////////////////////////////
	// Received characters from the link domain
	cscp_rx_if rx_bus ();

	cscp_uart_rx #(.T_BIT(T_RXB)) u_rx (
		.link_clk_i (link_clk_i),
		.arst_n_i   (arst_n_i),
		.rx_i       (sdi_rx_i),
		.baud_sel_i (baud_sel_i),
		.bus        (rx_bus.link)
	);

	logic       tg_s1, tg_s2, tg_s3;
	logic [7:0] rx_chr;

	always_ff @(posedge mclk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			tg_s1 <= 1'b0;
			tg_s2 <= 1'b0;
			tg_s3 <= 1'b0;
		end
		else
		begin
			tg_s1 <= rx_bus.tgl;
			tg_s2 <= tg_s1;
			tg_s3 <= tg_s2;
		end
	end

	assign rx_chr = rx_bus.chr;
	wire uart_evt = (tg_s2 ^ tg_s3) && !spi_mode;

	////////////////////////////////////////////////////////////////
	// UART command parsing: star, letter, carriage return
	logic       star;
	logic [1:0] pend;

	wire is_head   = (rx_chr == CH_UH);
	wire is_fld    = (rx_chr == CH_UM);
	wire commit    = uart_evt && (rx_chr == CH_CR) && (pend != PEND_NONE);
	wire [1:0] next_pend = (star && is_head) ? PEND_HEAD : (star && is_fld) ? PEND_FLD : PEND_NONE;

	always_ff @(posedge mclk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			star           <= 1'b0;
			pend           <= PEND_NONE;
			heading_mode_o <= 1'b1;
		end
		else if (uart_evt)
		begin
			star <= (rx_chr == CH_STAR);
			pend <= next_pend;
			if (commit)
				heading_mode_o <= (pend == PEND_HEAD);
		end
	end

	////////////////////////////////////////////////////////////////
	// SPI session engine; device makes the clock from its own timebase
	cscp_spi_st_t     st, next_st;
	logic [TMR_W-1:0] tmr, tmr_ld;
	logic [2:0]       bitn;
	logic [7:0]       shreg, spi_rx, lo_byte;
	logic             first, more;

	wire tmr_done = (tmr == '0);
	wire arm_done = (st == SP_ARM) && tmr_done && cs_act;
	wire rise     = (st == SP_LOW) && tmr_done && cs_act;
	wire fall     = (st == SP_HIGH) && tmr_done && cs_act;
	wire byte_end = fall && (bitn == 3'h7);
	wire cmd_ok   = (spi_rx == CH_UH) || (spi_rx == CH_LH);
	wire [7:0] hd_hi = heading_x10_i[15:8];

	always_comb
	begin
		next_st = st;
		case (st)
			SP_IDLE: if (cs_act) next_st = SP_ARM;
			SP_ARM:  if (tmr_done) next_st = SP_LOW;
			SP_LOW:  if (tmr_done) next_st = SP_HIGH;
			SP_HIGH: if (tmr_done) next_st = (bitn != 3'h7) ? SP_LOW :
				(first || more) ? SP_GAP : SP_DONE;
			SP_GAP:  if (tmr_done) next_st = SP_LOW;
			SP_DONE: next_st = SP_DONE;
			default: next_st = SP_IDLE;
		endcase
		// Chip select released ends or aborts the session
		if (!cs_act)
			next_st = SP_IDLE;
	end

	always_comb
	begin
		case (next_st)
			SP_ARM:  tmr_ld = TMR_W'(T_CS - 1);
			SP_LOW:  tmr_ld = TMR_W'(T_LO - 1);
			SP_HIGH: tmr_ld = TMR_W'(T_HI - 1);
			SP_GAP:  tmr_ld = TMR_W'(T_GAP - 1);
			default: tmr_ld = '0;
		endcase
	end

	always_ff @(posedge mclk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			st  <= SP_IDLE;
			tmr <= '0;
		end
		else
		begin
			st  <= next_st;
			tmr <= (next_st != st) ? tmr_ld : (tmr_done ? tmr : tmr - 1'b1);
		end
	end

	// Clock high only in the high phase, so it rests low otherwise
	always_ff @(posedge mclk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
			sck_o <= idle_clock_level_setting;
		else
			sck_o <= (next_st == SP_HIGH) ^ idle_clock_level_setting;
	end

	// Command bits sampled at the rising edge, MSB first
	always_ff @(posedge mclk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			spi_rx <= 8'h00;
			bitn   <= 3'h0;
		end
		else
		begin
			if (rise)
				spi_rx <= {spi_rx[6:0], sdi_f};
			if (arm_done)
				bitn <= 3'h0;
			else if (fall)
				bitn <= bitn + 3'h1;
		end
	end

	// Output byte shifts only at the falling edge
	always_ff @(posedge mclk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
			shreg <= 8'h00;
		else if (arm_done)
			shreg <= CH_S;
		else if (byte_end && first)
			shreg <= cmd_ok ? hd_hi : CH_E;
		else if (byte_end && more)
			shreg <= lo_byte;
		else if (fall)
			shreg <= {shreg[6:0], 1'b0};
	end

	// Heading is latched whole so both bytes come from one sample
	always_ff @(posedge mclk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			first   <= 1'b0;
			more    <= 1'b0;
			lo_byte <= 8'h00;
		end
		else if (arm_done)
		begin
			first <= 1'b1;
			more  <= 1'b0;
		end
		else if (byte_end)
		begin
			first <= 1'b0;
			more  <= first && cmd_ok;
			if (first)
				lo_byte <= heading_x10_i[7:0];
		end
	end

	////////////////////////////////////////////////////////////////
	// UART report transmitter; report text comes from the formatter
	cscp_tx_st_t      tx_st, next_tx;
	logic [9:0]       tx_sh;
	logic [3:0]       tx_bitn;
	logic [TMR_W-1:0] btmr;
	logic             tx_last;

	wire [TMR_W-1:0] bit_div = TMR_W'(T_BIT) << (2'h3 - baud_f);
	wire btmr_done = (btmr == '0);
	wire tx_go     = report_tick_i && !spi_mode && (tx_st == TX_IDLE);
	wire bit_end   = (tx_st == TX_SEND) && btmr_done;

	always_comb
	begin
		next_tx = tx_st;
		case (tx_st)
			TX_IDLE:  if (tx_go) next_tx = TX_FETCH;
			TX_FETCH: next_tx = TX_SEND;
			TX_SEND:  if (bit_end && tx_bitn == UART_LAST_BIT)
				next_tx = tx_last ? TX_IDLE : TX_FETCH;
			default:  next_tx = TX_IDLE;
		endcase
		if (spi_mode)
			next_tx = TX_IDLE;
	end

	always_ff @(posedge mclk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			tx_st        <= TX_IDLE;
			report_idx_o <= 6'h00;
		end
		else
		begin
			tx_st <= next_tx;
			if (tx_go)
				report_idx_o <= 6'h00;
			else if (tx_st == TX_SEND && next_tx == TX_FETCH)
				report_idx_o <= report_idx_o + 6'h01;
		end
	end

	always_ff @(posedge mclk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			tx_sh   <= 10'h3FF;
			tx_bitn <= 4'h0;
			btmr    <= '0;
			tx_last <= 1'b0;
		end
		else if (tx_st == TX_FETCH)
		begin
			tx_sh   <= {1'b1, report_char_i, 1'b0};
			tx_bitn <= 4'h0;
			btmr    <= bit_div - 1'b1;
			tx_last <= (report_char_i == CH_LF) || (report_idx_o == 6'h3F);
		end
		else if (bit_end)
		begin
			tx_sh   <= {1'b1, tx_sh[9:1]};
			tx_bitn <= tx_bitn + 4'h1;
			btmr    <= bit_div - 1'b1;
		end
		else if (tx_st == TX_SEND)
			btmr <= btmr - 1'b1;
	end

	// Shared data pin: SPI data in SPI mode, UART line otherwise
	wire next_sdo = spi_mode ? shreg[7] : ((tx_st == TX_SEND) ? tx_sh[0] : 1'b1);

	always_ff @(posedge mclk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
			sdo_tx_o <= 1'b1;
		else
			sdo_tx_o <= next_sdo;
	end

	////////////////////////////////////////////////////////////////
	// Checks
	logic [TMR_W-1:0] dwell;

	always_ff @(posedge mclk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
			dwell <= '0;
		else
			dwell <= (next_st != st) ? '0 : dwell + 1'b1;
	end

	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!arst_n_i);

	property p_rest_low;
		(st == SP_IDLE || st == SP_GAP || st == SP_DONE) |-> !sck_o;
	endproperty
	a_rest_low: assert property (p_rest_low)
		else $error("serial clock high outside a bit");

	property p_stable_high;
		spi_mode && sck_o && $past(sck_o) |-> $stable(sdo_tx_o);
	endproperty
	a_stable_high: assert property (p_stable_high)
		else $error("data changed while clock high");

	property p_arm_len;
		arm_done |-> dwell == TMR_W'(T_CS - 1);
	endproperty
	a_arm_len: assert property (p_arm_len)
		else $error("session opened before chip select time");

	property p_first_s;
		arm_done |=> (shreg == CH_S) && (st == SP_LOW) ##1 (sdo_tx_o == CH_S[7]);
	endproperty
	a_first_s: assert property (p_first_s)
		else $error("session did not open with s");

	property p_end;
		byte_end && !first && !more |=> (st == SP_DONE) && !sck_o;
	endproperty
	a_end: assert property (p_end)
		else $error("session not ended after last byte");

	property p_err;
		byte_end && first && !cmd_ok |=> (shreg == CH_E) && !more && (st == SP_GAP);
	endproperty
	a_err: assert property (p_err)
		else $error("unknown command not answered with e");

	property p_head;
		byte_end && first && cmd_ok |=> (shreg == $past(hd_hi)) && more;
	endproperty
	a_head: assert property (p_head)
		else $error("heading high byte not loaded");

	property p_low_len;
		rise |-> dwell == TMR_W'(T_LO - 1) ##1 sck_o;
	endproperty
	a_low_len: assert property (p_low_len)
		else $error("clock low phase wrong length");

	property p_high_len;
		fall |-> dwell == TMR_W'(T_HI - 1) ##1 !sck_o;
	endproperty
	a_high_len: assert property (p_high_len)
		else $error("clock high phase wrong length");

	property p_gap_len;
		(st == SP_GAP) && tmr_done && cs_act |-> dwell == TMR_W'(T_GAP - 1);
	endproperty
	a_gap_len: assert property (p_gap_len)
		else $error("byte gap wrong length");

	property p_start_bit;
		!spi_mode && (tx_st == TX_FETCH) ##1 !spi_mode |=> !sdo_tx_o;
	endproperty
	a_start_bit: assert property (p_start_bit)
		else $error("UART start bit missing");

	property p_baud;
		!spi_mode && (tx_st == TX_FETCH) && (baud_f == BAUD_SEL_19200) |=> btmr == TMR_W'(T_BIT - 1);
	endproperty
	a_baud: assert property (p_baud)
		else $error("default baud divisor wrong");

	property p_mode;
		commit |=> heading_mode_o == ($past(pend) == PEND_HEAD);
	endproperty
	a_mode: assert property (p_mode)
		else $error("report mode not taken from command");

endmodule : cscp_top

// ==== tb/cscp_host_model.sv ====
// Host-side partner model: SPI session peer and UART command sender
`timescale 1ns/1ps
module cscp_host_model
	import cscp_pkg::*;
#(
	parameter int T_LO  = 22,
	parameter int T_GAP = 50,
	parameter int T_HI  = 16,
	parameter int T_RXB = 16
)
(
	input  wire logic mclk_i,
	input  wire logic link_clk_i,
	input  wire logic sck_i,
	input  wire logic sdo_i,
	output logic      cs_n_o,
	output logic      sdi_o
);
	initial
	begin
		cs_n_o = 1'b1;
		sdi_o  = 1'b1;
	end
	////////////////////////////////////////////////////////////////////////////////
	// Cycles the device clock stays at one level, bounded against a hang
	task automatic hold_len(input logic lvl, output int c);
		c = 0;
		while (sck_i === lvl && c < 20000)
		begin
			@(posedge mclk_i);
			c++;
		end
	endtask : hold_len

	// Command goes out in the first byte; nb bytes are collected in all
	task automatic spi_session(input logic [7:0] cmd, input int nb,
		output logic [23:0] got, output int n_gap, output int n_bad);
		int c;
		got   = '0;
		n_gap = 0;
		n_bad = 0;
		@(posedge mclk_i);
		cs_n_o <= 1'b0;
		sdi_o  <= cmd[7];
		for (int i = 0; i < nb * 8; i++)
		begin
			hold_len(1'b0, c);
			if (i > 0 && i % 8 == 0 && c == T_LO + T_GAP)
				n_gap++;
			else if (i > 0 && c != T_LO)
				n_bad++;
			got = {got[22:0], sdo_i};
			hold_len(1'b1, c);
			if (c != T_HI)
				n_bad++;
			// Past the command the line toggles, never a stale level
			sdi_o <= (i < 7) ? cmd[6 - i] : ~sdi_o;
		end
		repeat (200)
		begin
			@(posedge mclk_i);
			if (sck_i !== 1'b0)
				n_bad++;
		end
		cs_n_o <= 1'b1;
		sdi_o  <= 1'b1;
		// Deselect must outlast the pin filter, or the next session is missed
		repeat (10) @(posedge mclk_i);
	endtask : spi_session

	// Deselect in the high phase of the first bit, then count clock cycles seen high
	task automatic spi_abort(output int n_rise);
		int c;
		@(posedge mclk_i);
		cs_n_o <= 1'b0;
		hold_len(1'b0, c);
		repeat (8) @(posedge mclk_i);
		cs_n_o <= 1'b1;
		n_rise = 0;
		repeat (10) @(posedge mclk_i);
		repeat (300)
		begin
			@(posedge mclk_i);
			if (sck_i !== 1'b0)
				n_rise++;
		end
	endtask : spi_abort

	// Trailing idle bit lets the receiver settle after a low stop bit
	task automatic uart_send(input logic [7:0] ch, input logic stop, input int sh);
		logic [10:0] fr;
		fr = {1'b1, stop, ch, 1'b0};
		for (int b = 0; b < 11; b++)
		begin
			@(posedge link_clk_i);
			sdi_o <= fr[b];
			repeat ((T_RXB << sh) - 1) @(posedge link_clk_i);
		end
	endtask : uart_send
endmodule : cscp_host_model

// ==== tb/cscp_top_tb.sv ====
// Self-checking bench of the compass serial command port
`timescale 1ns/1ps
module cscp_top_tb;
	import cscp_pkg::*;
	localparam int P_CS  = 20;
	localparam int P_LO  = 22;
	localparam int P_GAP = 50;
	localparam int P_BIT = 40;
	localparam int P_HI  = 16;
	localparam int P_RXB = 16;
	// Shortened timings; ceiling covers the slowest UART rates used
	localparam int LIMIT = 90000;
	localparam logic [7:0] TXT [3] = '{8'h4F, 8'h4B, CH_LF};
	logic        mclk_i;
	logic        link_clk_i;
	logic        arst_n_i;
	logic        spi_mode_i;
	logic [1:0]  baud_sel_i;
	logic [15:0] heading_x10_i;
	logic        report_tick_i;
	logic [7:0]  report_char_i;
	logic        cs_n, sdi, sck, sdo, heading_mode;
	logic [5:0]  report_idx;
	logic [23:0] got;
	int          n_gap, n_bad;
	int          error_cnt;
	int          n_tests;
	int          cyc = 0;

	always #2 mclk_i = ~mclk_i;
	initial
	begin
		link_clk_i = 1'b0;
		#13.7;
		forever #32 link_clk_i = ~link_clk_i;
	end
	assign report_char_i = (report_idx < 6'h03) ? TXT[report_idx[1:0]] : CH_STAR;

	cscp_top #(.T_CS(P_CS), .T_LO(P_LO), .T_GAP(P_GAP), .T_BIT(P_BIT), .T_HI(P_HI),
		.T_RXB(P_RXB)) u_dut (
		.mclk_i(mclk_i), .arst_n_i(arst_n_i), .link_clk_i(link_clk_i),
		.spi_mode_i(spi_mode_i), .baud_sel_i(baud_sel_i), .cs_n_i(cs_n),
		.sdi_rx_i(sdi), .heading_x10_i(heading_x10_i), .report_tick_i(report_tick_i),
		.report_char_i(report_char_i), .sck_o(sck), .sdo_tx_o(sdo),
		.report_idx_o(report_idx), .heading_mode_o(heading_mode));
	cscp_host_model #(.T_LO(P_LO), .T_GAP(P_GAP), .T_HI(P_HI), .T_RXB(P_RXB)) u_host (
		.mclk_i(mclk_i), .link_clk_i(link_clk_i), .sck_i(sck), .sdo_i(sdo),
		.cs_n_o(cs_n), .sdi_o(sdi));
	////////////////////////////////////////////////////////////////////////////////
	task automatic check(input string what, input logic [23:0] exp, input logic [23:0] seen);
		n_tests++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("unexpected %s: expected %h, seen %h", what, exp, seen);
		end
	endtask : check

	task automatic report_and_stop();
		$display("checks %0d, mismatches %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : report_and_stop

	always @(posedge mclk_i)
	begin
		cyc++;
		if (cyc == LIMIT)
		begin
			error_cnt++;
			report_and_stop();
		end
	end

	task automatic pulse_tick();
		@(posedge mclk_i);
		report_tick_i <= 1'b1;
		@(posedge mclk_i);
		report_tick_i <= 1'b0;
	endtask : pulse_tick

	// Mid-bit sampling of one character on the shared output line
	task automatic uart_take(input int bit_c, output logic [9:0] fr);
		int c;
		c = 0;
		while (sdo !== 1'b0 && c < 40000)
		begin
			@(posedge mclk_i);
			c++;
		end
		repeat (bit_c / 2) @(posedge mclk_i);
		for (int b = 0; b < 10; b++)
		begin
			fr[b] = sdo;
			if (b < 9)
				repeat (bit_c) @(posedge mclk_i);
		end
	endtask : uart_take
	////////////////////////////////////////////////////////////////////////////////
	task automatic t_uart_tx();
		logic [9:0] fr;
		int         bit_c;
		int         n_low;
		for (int s = 3; s >= 0; s--)
		begin
			bit_c = P_BIT << (3 - s);
			@(posedge mclk_i);
			baud_sel_i <= s[1:0];
			repeat (10) @(posedge mclk_i);
			pulse_tick();
			for (int k = 0; k < 3; k++)
			begin
				uart_take(bit_c, fr);
				check("uart frame", {14'h0, 1'b1, TXT[k], 1'b0}, {14'h0, fr});
				// Tick while busy must not restart the report
				if (k == 0)
					pulse_tick();
			end
			n_low = 0;
			repeat (12 * bit_c)
			begin
				@(posedge mclk_i);
				if (sdo !== 1'b1)
					n_low++;
			end
			check("idle after line end", 24'h0, n_low[23:0]);
			check("last report index", 24'h2, {18'h0, report_idx});
		end
		$display("test uart transmit done");
	endtask : t_uart_tx

	task automatic t_uart_rx();
		@(posedge mclk_i);
		baud_sel_i <= 2'h3;
		// Letter with a low stop bit is dropped, so the line end commits nothing
		u_host.uart_send(CH_STAR, 1'b1, 0);
		u_host.uart_send(CH_UM, 1'b0, 0);
		u_host.uart_send(CH_CR, 1'b1, 0);
		repeat (200) @(posedge mclk_i);
		check("mode after bad stop", 24'h1, {23'h0, heading_mode});
		u_host.uart_send(CH_STAR, 1'b1, 0);
		u_host.uart_send(CH_UM, 1'b1, 0);
		u_host.uart_send(CH_CR, 1'b1, 0);
		repeat (200) @(posedge mclk_i);
		check("field report mode", 24'h0, {23'h0, heading_mode});
		@(posedge mclk_i);
		baud_sel_i <= 2'h2;
		repeat (200) @(posedge mclk_i);
		u_host.uart_send(CH_STAR, 1'b1, 1);
		u_host.uart_send(CH_UH, 1'b1, 1);
		u_host.uart_send(CH_CR, 1'b1, 1);
		repeat (200) @(posedge mclk_i);
		check("heading report mode", 24'h1, {23'h0, heading_mode});
		$display("test uart command done");
	endtask : t_uart_rx

	task automatic t_spi_abort();
		@(posedge mclk_i);
		spi_mode_i <= 1'b1;
		repeat (10) @(posedge mclk_i);
		u_host.spi_abort(n_bad);
		check("clock after deselect", 24'h0, n_bad[23:0]);
		$display("test spi abort done");
	endtask : t_spi_abort

	task automatic t_spi_heading();
		@(posedge mclk_i);
		heading_x10_i <= 16'h0E0B;
		u_host.spi_session(CH_LH, 3, got, n_gap, n_bad);
		check("heading reply", {CH_S, 16'h0E0B}, got);
		check("byte gaps", 24'h2, n_gap[23:0]);
		check("clock phases", 24'h0, n_bad[23:0]);
		$display("test spi heading done");
	endtask : t_spi_heading

	task automatic t_spi_error();
		u_host.spi_session(CH_UM, 2, got, n_gap, n_bad);
		check("error reply", {8'h00, CH_S, CH_E}, got);
		check("byte gaps", 24'h1, n_gap[23:0]);
		check("session end", 24'h0, n_bad[23:0]);
		$display("test spi error done");
	endtask : t_spi_error
	////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		mclk_i        = 1'b0;
		arst_n_i      = 1'b0;
		spi_mode_i    = 1'b0;
		baud_sel_i    = 2'h3;
		heading_x10_i = 16'h0000;
		report_tick_i = 1'b0;
		error_cnt     = 0;
		n_tests       = 0;
		// Held over link clock cycles so both domains see the reset
		repeat (3) @(posedge link_clk_i);
		@(posedge mclk_i);
		arst_n_i <= 1'b1;
		@(posedge mclk_i);
		check("clock at rest", 24'h0, {23'h0, sck});
		check("line idle", 24'h1, {23'h0, sdo});
		check("reset report mode", 24'h1, {23'h0, heading_mode});
		t_uart_tx();
		t_uart_rx();
		t_spi_abort();
		t_spi_heading();
		t_spi_error();
		report_and_stop();
	end
endmodule : cscp_top_tb
